/* File: dflash_part_pkg.sv */
// constants and types shared by the data flash partition command logic
`default_nettype none
package dflash_part_pkg;
  // sector geometry: partition sizes count 256-byte sectors
  localparam int unsigned SECTOR_BYTES   = 256;
  localparam int unsigned SECTOR_BITS    = 8;
  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0]  OFS_STATUS     = 8'h00;
  localparam logic [7:0]  OFS_INDEX      = 8'h04;
  localparam logic [7:0]  OFS_PARAM      = 8'h08;
  localparam logic [7:0]  OFS_CTRL       = 8'h0C;
  localparam logic [7:0]  OFS_PART       = 8'h10;
  localparam logic [7:0]  OFS_USER_END   = 8'h14;
  localparam logic [7:0]  OFS_BUF_START  = 8'h18;
  // flash_status_register bit positions
  localparam int unsigned ST_CCF         = 0;
  localparam int unsigned ST_ACCESS_ERROR_FLAG      = 1;
  localparam int unsigned ST_VERR        = 2;
  localparam int unsigned ST_UERR        = 3;
  // control register bit positions and reset value
  localparam int unsigned CTRL_MODE_OK   = 0;
  localparam int unsigned CTRL_LOAD_ACT  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h1;
  // partition register field positions
  localparam int unsigned PART_BUF_LSB   = 8;
  localparam int unsigned PART_DEF_BIT   = 16;
  // command parameter array layout
  localparam logic [2:0]  IDX_CMD        = 3'h0;
  localparam logic [2:0]  IDX_USER       = 3'h1;
  localparam logic [2:0]  IDX_BUF        = 3'h2;
  localparam logic [15:0] CMD_PARTITION  = 16'h0020;
  // validation limits
  localparam logic [15:0] MAX_USER       = 16'h0080;
  localparam logic [15:0] MAX_BUF        = 16'h0008;
  localparam logic [15:0] MIN_REMAIN     = 16'h000C;
  localparam int unsigned RATIO_SHIFT    = 3;
  // global addresses
  localparam logic [23:0] ADDR_INFO_USER = 24'h12_0000;
  localparam logic [23:0] ADDR_INFO_UDUP = 24'h12_0002;
  localparam logic [23:0] ADDR_INFO_BUF  = 24'h12_0004;
  localparam logic [23:0] ADDR_INFO_BDUP = 24'h12_0006;
  localparam logic [23:0] ADDR_USER_BASE = 24'h10_0000;
  localparam logic [23:0] ADDR_BUF_TOP   = 24'h13_FFFF;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    OP_VERIFY_BLOCK = 2'b00,
    OP_VERIFY_INFO  = 2'b01,
    OP_PROGRAM      = 2'b10
  } nvm_op_t;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_VFY_BLK  = 3'b001,
    S_VFY_INFO = 3'b010,
    S_PROG     = 3'b011,
    S_DONE     = 3'b100
  } seq_state_t;
endpackage : dflash_part_pkg
`default_nettype wire

/* File: seq_if.sv */
// carrier between the register front end and the array sequencer
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
  logic       start;
  logic [7:0] user_cnt;
  logic [7:0] buf_cnt;
  logic       done;
  logic       verify_err;
  logic       ecc_err;
  modport ctl (output start, output user_cnt, output buf_cnt,
               input done, input verify_err, input ecc_err);
  modport seq (input start, input user_cnt, input buf_cnt,
               output done, output verify_err, output ecc_err);
endinterface : seq_if
`default_nettype wire

/* File: partition_sequencer.sv */
// erase-verify and information register programming sequence
`timescale 1ns/1ps
`default_nettype none
module partition_sequencer
  import dflash_part_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // command side
  seq_if.seq               ctl,
  // nonvolatile array side
  output var  logic        nvm_req,
  output var  nvm_op_t     nvm_op,
  output var  logic [23:0] nvm_addr,
  output var  logic [15:0] nvm_wdata,
  input  wire logic        nvm_ack,
  input  wire logic        nvm_read_err,
  input  wire logic        nvm_ecc_err
);
  seq_state_t state_r;
  logic [1:0] prog_idx_r;
  logic [7:0] user_r;
  logic [7:0] buf_r;
  logic       verified_r;

  function automatic logic [23:0] prog_addr(input logic [1:0] idx);
    case (idx)
      2'h0:    prog_addr = ADDR_INFO_USER;
      2'h1:    prog_addr = ADDR_INFO_UDUP;
      2'h2:    prog_addr = ADDR_INFO_BUF;
      default: prog_addr = ADDR_INFO_BDUP;
    endcase
  endfunction : prog_addr

  wire        step_fail = nvm_ack && (nvm_read_err || nvm_ecc_err);
  wire        step_ok   = nvm_ack && !nvm_read_err && !nvm_ecc_err;
  wire [1:0]  next_idx  = prog_idx_r + 2'h1;
  wire [15:0] next_data = {8'h00, next_idx[1] ? buf_r : user_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r        <= S_IDLE;
      prog_idx_r     <= 2'h0;
      user_r         <= 8'h00;
      buf_r          <= 8'h00;
      verified_r     <= 1'b0;
      nvm_req        <= 1'b0;
      nvm_op         <= OP_VERIFY_BLOCK;
      nvm_addr       <= 24'h00_0000;
      nvm_wdata      <= 16'h0000;
      ctl.done       <= 1'b0;
      ctl.verify_err <= 1'b0;
      ctl.ecc_err    <= 1'b0;
    end else begin
      ctl.done <= 1'b0;
      if (step_fail) begin
        ctl.verify_err <= 1'b1; // see R20
        ctl.ecc_err    <= ctl.ecc_err | nvm_ecc_err; // see R21
      end
      case (state_r)
        S_IDLE: begin
          if (ctl.start) begin
            state_r        <= S_VFY_BLK; // see R9
            user_r         <= ctl.user_cnt;
            buf_r          <= ctl.buf_cnt;
            verified_r     <= 1'b0;
            ctl.verify_err <= 1'b0;
            ctl.ecc_err    <= 1'b0;
            nvm_req        <= 1'b1;
            nvm_op         <= OP_VERIFY_BLOCK;
            nvm_addr       <= ADDR_USER_BASE;
          end
        end
        S_VFY_BLK: begin
          if (step_ok) begin
            state_r  <= S_VFY_INFO; // see R9
            nvm_op   <= OP_VERIFY_INFO;
            nvm_addr <= ADDR_INFO_USER;
          end
        end
        S_VFY_INFO: begin
          if (step_ok) begin
            state_r    <= S_PROG;
            verified_r <= 1'b1;
            prog_idx_r <= 2'h0;
            nvm_op     <= OP_PROGRAM;
            nvm_addr   <= prog_addr(2'h0); // see R10
            nvm_wdata  <= {8'h00, user_r};
          end
        end
        S_PROG: begin
          if (step_ok && prog_idx_r == 2'h3) begin
            state_r <= S_DONE;
            nvm_req <= 1'b0;
          end else if (step_ok) begin
            prog_idx_r <= next_idx;
            nvm_addr   <= prog_addr(next_idx); // see R10 see R11
            nvm_wdata  <= next_data;
          end
        end
        S_DONE: begin
          ctl.done <= 1'b1;
          state_r  <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
      // a failed read ends the sequence without programming further
      if (step_fail && state_r != S_IDLE && state_r != S_DONE) begin
        state_r <= S_DONE;
        nvm_req <= 1'b0;
      end
    end
  end

  property p_program_after_verify;
    @(posedge aclk) disable iff (!aresetn)
      (nvm_req && nvm_op == OP_PROGRAM) |-> verified_r;
  endproperty
  a_program_after_verify: assert property (p_program_after_verify) // see R9
    else $error("program request issued before erase verify passed");

  property p_user_copies;
    @(posedge aclk) disable iff (!aresetn)
      (nvm_req && nvm_op == OP_PROGRAM && !nvm_addr[2])
        |-> nvm_wdata == {8'h00, user_r};
  endproperty
  a_user_copies: assert property (p_user_copies) // see R10
    else $error("user count copy carries the wrong value");

  property p_buf_copies;
    @(posedge aclk) disable iff (!aresetn)
      (nvm_req && nvm_op == OP_PROGRAM && nvm_addr[2])
        |-> nvm_wdata == {8'h00, buf_r};
  endproperty
  a_buf_copies: assert property (p_buf_copies) // see R11
    else $error("buffer count copy carries the wrong value");

  property p_read_err_flags;
    @(posedge aclk) disable iff (!aresetn)
      (state_r != S_IDLE && nvm_ack && nvm_read_err) |=> ##1 ctl.done
        && ctl.verify_err;
  endproperty
  a_read_err_flags: assert property (p_read_err_flags) // see R20
    else $error("read error did not end the sequence with verify error");

  property p_ecc_err_flags;
    @(posedge aclk) disable iff (!aresetn)
      (state_r != S_IDLE && nvm_ack && nvm_ecc_err) |=> ##1 ctl.ecc_err;
  endproperty
  a_ecc_err_flags: assert property (p_ecc_err_flags) // see R21
    else $error("uncorrectable read did not raise its status");
endmodule : partition_sequencer
`default_nettype wire

/* File: dflash_partition_command.sv */
// data flash partition command: register front end and launch checks
//
// Function
// R1 - data flash counts whole 256-byte sectors in every size parameter
// R2 - software runs erase-all-blocks before launching the partition command
// R3 - parameters: slot 0 code 0x20, slot 1 user count, slot 2 buffer count
// R4 - clearing the completion flag launches validation and programming
// R5 - user sector count above 128 is rejected
// R6 - buffer RAM sector count above 8 is rejected
// R7 - nonzero buffer count needs at least 12 sectors left after user part
// R8 - nonzero buffer count needs remaining sectors per buffer sector of 8
// R9 - erase-verify flash block and information register before programming
// R10 - user count programmed at 0x12_0000 and duplicate at 0x12_0002
// R11 - buffer count programmed at 0x12_0004 and duplicate at 0x12_0006
// R12 - user partition starts at 0x10_0000 growing upward by its count
// R13 - buffer partition ends at 0x13_FFFF growing downward by its count
// R14 - completion flag sets when the operation has finished
// R15 - relaunch after partitions are defined sets the access error flag
// R16 - parameter index other than 2 at launch sets the access error flag
// R17 - launch during an active load-data-field sequence sets access error
// R18 - launch not permitted in the current mode sets access error
// R19 - any failed count check sets the access error flag
// R20 - any read error during the operation sets verify error status
// R21 - any uncorrectable read error sets uncorrectable error status
// R22 - launch errors skip all array work and set completion again
`timescale 1ns/1ps
`default_nettype none
module dflash_partition_command
  import dflash_part_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // nonvolatile array and information register
  output var  logic        nvm_req,
  output var  nvm_op_t     nvm_op,
  output var  logic [23:0] nvm_addr,
  output var  logic [15:0] nvm_wdata,
  input  wire logic        nvm_ack,
  input  wire logic        nvm_read_err,
  input  wire logic        nvm_ecc_err
);
  seq_if sq ();

  logic [15:0] param_r [0:7];
  logic [2:0]  parameter_index_r;
  logic [1:0]  ctrl_r;
  logic        command_complete_flag_r;
  logic        access_error_flag_r;
  logic        verify_error_status_r;
  logic        uncorrectable_error_status_r;
  logic        defined_r;
  logic [7:0]  user_sector_count_r;
  logic [7:0]  buffer_ram_sector_count_r;
  logic        start_r;
  logic [7:0]  nvm_user_q;
  logic [7:0]  nvm_buf_q;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_STATUS) || (a == OFS_INDEX) || (a == OFS_PARAM) ||
             (a == OFS_CTRL) || (a == OFS_PART) || (a == OFS_USER_END) ||
             (a == OFS_BUF_START);
  endfunction : mapped

  // write path: address and data are taken together in one edge
  // nothing more is taken until the response has been accepted
  wire        wr_take   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                          && !s_axi_bvalid;
  wire        wr_status = wr_take && s_axi_awaddr == OFS_STATUS
                          && s_axi_wstrb[0];
  wire        wr_index  = wr_take && s_axi_awaddr == OFS_INDEX
                          && s_axi_wstrb[0];
  wire        wr_param  = wr_take && s_axi_awaddr == OFS_PARAM;
  wire        wr_ctrl   = wr_take && s_axi_awaddr == OFS_CTRL
                          && s_axi_wstrb[0];
  wire        rd_take   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // a launch is a one written to a set completion flag
  wire        launch    = wr_status && s_axi_wdata[ST_CCF]
                          && command_complete_flag_r; // see R4
  wire        clr_acc   = wr_status && s_axi_wdata[ST_ACCESS_ERROR_FLAG];

  // launch checks
  wire [15:0] cmd_word  = param_r[IDX_CMD];
  wire [15:0] user_req  = param_r[IDX_USER]; // see R3
  wire [15:0] buf_req   = param_r[IDX_BUF];
  wire [15:0] remain    = MAX_USER - user_req;
  wire        buf_on    = buf_req != 16'h0000;
  wire        user_bad  = user_req > MAX_USER; // see R5
  wire        buf_bad   = buf_req > MAX_BUF; // see R6
  wire        rem_bad   = buf_on && !user_bad
                          && remain < MIN_REMAIN; // see R7
  // floor division by the buffer count compares as a multiply
  wire        ratio_bad = buf_on && !user_bad
                          && remain < (buf_req << RATIO_SHIFT); // see R8
  wire        cnt_bad   = user_bad || buf_bad || rem_bad || ratio_bad;
  wire        idx_bad   = parameter_index_r != IDX_BUF; // see R16
  wire        load_busy = ctrl_r[CTRL_LOAD_ACT]; // see R17
  wire        mode_bad  = !ctrl_r[CTRL_MODE_OK]
                          || cmd_word != CMD_PARTITION; // see R18
  wire        launch_err = idx_bad || load_busy || mode_bad || defined_r
                           || cnt_bad; // see R15 see R19

  // partition bounds in sectors of 256 bytes
  wire [23:0] user_span = {8'h00, user_sector_count_r, 8'h00}; // see R1
  wire [23:0] buf_span  = {8'h00, buffer_ram_sector_count_r, 8'h00};
  wire [23:0] user_end  = ADDR_USER_BASE + user_span; // see R12
  wire [23:0] buf_start = ADDR_BUF_TOP - buf_span + 24'h00_0001; // see R13

  wire [31:0] status_word = {28'h000_0000, uncorrectable_error_status_r,
                             verify_error_status_r, access_error_flag_r,
                             command_complete_flag_r};
  wire [31:0] part_word   = {15'h0000, defined_r, buffer_ram_sector_count_r,
                             user_sector_count_r};
  wire [31:0] rd_word =
      (s_axi_araddr == OFS_STATUS)    ? status_word :
      (s_axi_araddr == OFS_INDEX)     ? {29'h0000_0000, parameter_index_r} :
      (s_axi_araddr == OFS_PARAM)     ? {16'h0000,
                                         param_r[parameter_index_r]} :
      (s_axi_araddr == OFS_CTRL)      ? {30'h0000_0000, ctrl_r} :
      (s_axi_araddr == OFS_PART)      ? part_word :
      (s_axi_araddr == OFS_USER_END)  ? {8'h00, user_end} :
      (s_axi_araddr == OFS_BUF_START) ? {8'h00, buf_start} :
                                        32'h0000_0000;

  assign sq.start    = start_r;
  assign sq.user_cnt = user_req[7:0];
  assign sq.buf_cnt  = buf_req[7:0];

  // bus handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      s_axi_awready <= wr_take;
      s_axi_wready  <= wr_take;
      s_axi_arready <= rd_take;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // parameter array, one slot per index value
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_param
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          param_r[gi] <= 16'h0000;
        end else if (wr_param && parameter_index_r == 3'(gi)) begin
          if (s_axi_wstrb[0]) param_r[gi][7:0]  <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) param_r[gi][15:8] <= s_axi_wdata[15:8];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parameter_index_r <= 3'h0;
      ctrl_r            <= CTRL_RESET;
    end else begin
      if (wr_index) parameter_index_r <= s_axi_wdata[2:0];
      if (wr_ctrl)  ctrl_r            <= s_axi_wdata[1:0];
    end
  end

  // command state and status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_complete_flag_r      <= 1'b1;
      access_error_flag_r          <= 1'b0;
      verify_error_status_r        <= 1'b0;
      uncorrectable_error_status_r <= 1'b0;
      defined_r                    <= 1'b0;
      user_sector_count_r          <= 8'h00;
      buffer_ram_sector_count_r    <= 8'h00;
      start_r                      <= 1'b0;
    end else begin
      start_r <= 1'b0;
      // the set below wins over a clear in the same write
      if (clr_acc) access_error_flag_r <= 1'b0;
      if (launch && launch_err) begin
        access_error_flag_r <= 1'b1; // see R22
      end else if (launch) begin
        command_complete_flag_r      <= 1'b0; // see R4
        verify_error_status_r        <= 1'b0;
        uncorrectable_error_status_r <= 1'b0;
        start_r                      <= 1'b1;
      end
      if (sq.done) begin
        command_complete_flag_r      <= 1'b1; // see R14
        verify_error_status_r        <= sq.verify_err; // see R20
        uncorrectable_error_status_r <= sq.ecc_err; // see R21
        if (!sq.verify_err && !sq.ecc_err) begin
          defined_r                 <= 1'b1;
          user_sector_count_r       <= nvm_user_q;
          buffer_ram_sector_count_r <= nvm_buf_q;
        end
      end
    end
  end

  // counts captured at launch for the bound registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_user_q <= 8'h00;
      nvm_buf_q  <= 8'h00;
    end else if (start_r) begin
      nvm_user_q <= user_req[7:0];
      nvm_buf_q  <= buf_req[7:0];
    end
  end

  partition_sequencer u_seq (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ctl          (sq.seq),
    .nvm_req      (nvm_req),
    .nvm_op       (nvm_op),
    .nvm_addr     (nvm_addr),
    .nvm_wdata    (nvm_wdata),
    .nvm_ack      (nvm_ack),
    .nvm_read_err (nvm_read_err),
    .nvm_ecc_err  (nvm_ecc_err)
  );

  sequence s_reject;
    ##1 access_error_flag_r && command_complete_flag_r && !start_r;
  endsequence

  property p_bad_index;
    @(posedge aclk) disable iff (!aresetn) (launch && idx_bad) |-> s_reject;
  endproperty
  a_bad_index: assert property (p_bad_index) // see R16
    else $error("wrong parameter index was not rejected");

  property p_user_limit;
    @(posedge aclk) disable iff (!aresetn)
      (launch && user_req > 16'h0080) |-> s_reject;
  endproperty
  a_user_limit: assert property (p_user_limit) // see R5
    else $error("user sector count above limit was accepted");

  property p_buf_limit;
    @(posedge aclk) disable iff (!aresetn)
      (launch && buf_req > 16'h0008) |-> s_reject;
  endproperty
  a_buf_limit: assert property (p_buf_limit) // see R6
    else $error("buffer sector count above limit was accepted");

  property p_remain;
    @(posedge aclk) disable iff (!aresetn)
      (launch && buf_on && user_req <= 16'h0080
       && (16'h0080 - user_req) < 16'h000C) |-> s_reject;
  endproperty
  a_remain: assert property (p_remain) // see R7
    else $error("too few remaining sectors were accepted");

  property p_ratio;
    @(posedge aclk) disable iff (!aresetn)
      (launch && buf_on && user_req <= 16'h0080
       && (16'h0080 - user_req) / buf_req < 16'h0008) |-> s_reject;
  endproperty
  a_ratio: assert property (p_ratio) // see R8
    else $error("sector ratio below eight was accepted");

  property p_relaunch;
    @(posedge aclk) disable iff (!aresetn)
      (launch && (defined_r || load_busy || !ctrl_r[CTRL_MODE_OK]))
        |-> s_reject;
  endproperty
  a_relaunch: assert property (p_relaunch) // see R15 see R17 see R18
    else $error("illegal launch was not rejected");

  property p_good_launch;
    @(posedge aclk) disable iff (!aresetn)
      (launch && !launch_err) |=> !command_complete_flag_r ##1 nvm_req;
  endproperty
  a_good_launch: assert property (p_good_launch) // see R4 see R9
    else $error("valid launch did not start the array sequence");

  property p_complete;
    @(posedge aclk) disable iff (!aresetn)
      sq.done |=> command_complete_flag_r;
  endproperty
  a_complete: assert property (p_complete) // see R14
    else $error("completion flag did not set after the sequence");

  property p_bad_code;
    @(posedge aclk) disable iff (!aresetn)
      (launch && cmd_word != CMD_PARTITION) |-> s_reject;
  endproperty
  a_bad_code: assert property (p_bad_code) // see R18
    else $error("wrong command code was not rejected");

  property p_skip_array;
    @(posedge aclk) disable iff (!aresetn)
      (launch && launch_err) |=> !start_r ##1 !nvm_req ##1 !nvm_req;
  endproperty
  a_skip_array: assert property (p_skip_array) // see R22
    else $error("rejected launch reached the array");

  property p_define;
    @(posedge aclk) disable iff (!aresetn)
      (sq.done && !sq.verify_err && !sq.ecc_err) |=> defined_r;
  endproperty
  a_define: assert property (p_define) // see R15
    else $error("clean sequence did not mark partitions defined");
endmodule : dflash_partition_command
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the partition command block
`timescale 1ns/1ps
`default_nettype none
module tb_top import dflash_part_pkg::*;;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
  logic aclk = 0, aresetn = 0, nvm_ack = 0, inj_v = 0, inj_e = 0;
  logic awvalid, wvalid, bready, arvalid, rready, nvm_req;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, resp;
  nvm_op_t nvm_op;
  logic [23:0] nvm_addr;
  logic [15:0] nvm_wdata;
  logic [41:0] log_q[$];
  logic [31:0] seed = 32'h0867;
  int err_total = 0, compares = 0;
  always #5 aclk = ~aclk;
  dflash_partition_command i_dflash_partition_command (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nvm_req(nvm_req),
    .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_ack(nvm_ack), .nvm_read_err(inj_v), .nvm_ecc_err(inj_e));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic bit ok(int u, int b);
    return u <= 128 && b <= 8 && (b == 0 || (128 - u >= 12 && (128 - u) / b >= 8));
  endfunction : ok
  function automatic logic [25:0] exp_oa(int i);
    if (i == 0) return {OP_VERIFY_BLOCK, ADDR_USER_BASE};
    if (i == 1) return {OP_VERIFY_INFO, ADDR_INFO_USER};
    return {OP_PROGRAM, ADDR_INFO_USER + 24'(2 * (i - 2))};
  endfunction : exp_oa
  // array starts erased, answers after a random wait, logs each request
  always @(posedge aclk) begin
    nvm_ack <= nvm_req && !nvm_ack && rnd() % 3 != 0;
    if (nvm_req && nvm_ack) log_q.push_back({nvm_op, nvm_addr, nvm_wdata});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic launch(input int u, input int b, input logic [2:0] ix,
                        input logic [31:0] ex);
    logic [31:0] d;
    logic [15:0] pv[3];
    pv = '{CMD_PARTITION, 16'(u), 16'(b)};
    log_q.delete();
    for (int i = 0; i < 3; i++) begin
      wr(OFS_INDEX, 32'(i));
      wr(OFS_PARAM, {16'h0, pv[i]});
    end
    wr(OFS_INDEX, {29'h0, ix});
    wr(OFS_STATUS, 32'h3);
    do rd(OFS_STATUS, d); while (!d[0]);
    `CHK(d, ex)
    $display("test launch u=%0d b=%0d done", u, b);
  endtask : launch
  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    int u, b;
    int cu[4], cb[4];
    cu = '{129, 0, 117, 72};
    cb = '{0, 9, 1, 8};
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, d);
    `CHK(d, 32'h1)
    rd(OFS_CTRL, d);
    `CHK(d, 32'h1)
    rd(8'h40, d);
    `CHK({resp, d}, {RESP_SLVERR, 32'h0})
    wr(8'h40, 32'h0);
    `CHK(resp, RESP_SLVERR)
    launch(100, 0, 3'h1, 32'h3);
    `CHK(log_q.size(), 0)
    wr(OFS_CTRL, 32'h3);
    launch(0, 0, 3'h2, 32'h3);
    wr(OFS_CTRL, 32'h0);
    launch(0, 0, 3'h2, 32'h3);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_INDEX, 32'h0);
    wr(OFS_PARAM, 32'h21);
    wr(OFS_INDEX, 32'h2);
    wr(OFS_STATUS, 32'h3);
    rd(OFS_STATUS, d);
    `CHK(d, 32'h3)
    $display("test wrong command code done");
    for (int k = 0; k < 4; k++) launch(cu[k], cb[k], 3'h2, 32'h3);
    for (int k = 0; k < 20; k++) begin
      u = rnd() % 192;
      b = rnd() % 12;
      if (!ok(u, b)) launch(u, b, 3'h2, 32'h3);
    end
    // ratio exactly at its limit is still accepted
    launch(64, 8, 3'h2, 32'h1);
    `CHK(log_q.size(), 6)
    for (int i = 0; i < 6; i++) begin
      `CHK(log_q[i][41:16], exp_oa(i))
      if (i > 1) `CHK(log_q[i][15:0], i < 4 ? 16'h40 : 16'h8)
    end
    rd(OFS_PART, d);
    `CHK(d, 32'h0001_0840)
    rd(OFS_USER_END, d);
    `CHK(d, 32'h0010_4000)
    rd(OFS_BUF_START, d);
    `CHK(d, 32'h0013_F800)
    launch(64, 8, 3'h2, 32'h3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    inj_v <= 1'b1;
    launch(0, 0, 3'h2, 32'h5);
    inj_e <= 1'b1;
    launch(0, 0, 3'h2, 32'hD);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
